//--- core/tws_pin_sync.v
// Two-flop synchroniser for pins that arrive from outside clk_sys.
// Assumes the pins are plain levels; only the second stage is read.
`timescale 1ns/1ps

module tws_pin_sync #(
   parameter WIDTH = 4
) (
   input wire clk_sys,
   input wire sys_rst,
   input wire [WIDTH-1:0] pinAsync,
   input wire [WIDTH-1:0] pinIdle,
   output wire [WIDTH-1:0] pinSync
);

   // ==================================================
   // Synchroniser stages
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // Reset loads each pin's idle level, so no false edge follows reset
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         meta_reg <= pinIdle;
         sync_reg <= pinIdle;
      end else begin
         meta_reg <= pinAsync;
         sync_reg <= meta_reg;
      end
   end

   assign pinSync = sync_reg;

endmodule // tws_pin_sync

//--- core/tws_reg_bank.v
// Control register bank written and read by the two-wire slave.
// Assumes one-cycle write strobes and status inputs on clk_sys.
`timescale 1ns/1ps
`include "tws_map.vh"

module tws_reg_bank (
   input wire clk_sys,
   input wire sys_rst,
   input wire wrEn,
   input wire [7:0] regAddr,
   input wire [7:0] wrData,
   input wire [3:0] selRateStatus,
   input wire [6:0] selLosStatus,
   output reg [7:0] rdData,
   output wire [3:0] ctrlBits,
   output wire [7:0] sliceCode,
   output wire [3:0] preemphCode,
   output wire [1:0] swingCode,
   output wire [4:0] bwA,
   output wire [4:0] bwB
);

   // ==================================================
   // Storage, only the implemented bits exist
   reg [3:0] ctrl_reg;
   reg [7:0] slice_reg;
   reg [3:0] preemph_reg;
   reg [1:0] swing_reg;
   reg [4:0] bwA_reg;
   reg [4:0] bwB_reg;

   // Writes beyond the implemented bits are simply dropped
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_reg <= `TWS_RST_CTRL;
         slice_reg <= `TWS_RST_SLICE;
         preemph_reg <= `TWS_RST_PREEMPH;
         swing_reg <= `TWS_RST_SWING;
         bwA_reg <= `TWS_RST_BW;
         bwB_reg <= `TWS_RST_BW;
      end else if (wrEn) begin
         case (regAddr)
            `TWS_REG_CTRL: ctrl_reg <= wrData[3:0];
            `TWS_REG_SLICE: slice_reg <= wrData;
            `TWS_REG_PREEMPH: preemph_reg <= wrData[3:0];
            `TWS_REG_SWING: swing_reg <= wrData[1:0];
            `TWS_REG_BW_A: bwA_reg <= {wrData[7], wrData[3:0]};
            `TWS_REG_BW_B: bwB_reg <= {wrData[7], wrData[3:0]};
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Read mux; unused bits and slots kept elsewhere read as zero
   always @* begin
      case (regAddr)
         `TWS_REG_CTRL: rdData = {4'h0, ctrl_reg};
         `TWS_REG_SLICE: rdData = slice_reg;
         `TWS_REG_PREEMPH: rdData = {4'h0, preemph_reg};
         `TWS_REG_SWING: rdData = {6'h00, swing_reg};
         `TWS_REG_BW_A: rdData = {bwA_reg[4], 3'h0, bwA_reg[3:0]};
         `TWS_REG_BW_B: rdData = {bwB_reg[4], 3'h0, bwB_reg[3:0]};
         `TWS_REG_SEL_RATE: rdData = {4'h0, selRateStatus};
         `TWS_REG_SEL_LOS: rdData = {1'b0, selLosStatus};
         default: rdData = 8'h00;
      endcase
   end

   assign ctrlBits = ctrl_reg;
   assign sliceCode = slice_reg;
   assign preemphCode = preemph_reg;
   assign swingCode = swing_reg;
   assign bwA = bwA_reg;
   assign bwB = bwB_reg;

endmodule // tws_reg_bank

//--- core/tws_slave_top.v
// Two-wire serial slave with the amplifier control register bank.
// Assumes SCK and SDA are open-drain pins sampled by clk_sys, with a
// master clock far below clk_sys so every bus edge is seen.
//
// Behaviour
// - Target only; master drives clock and conditions.
// - Answer only address 1000100 plus direction bit.
// - Order: start, address, register, data, stop.
// - Both lines high means the bus is idle.
// - Data falling while clock high is start.
// - Data rising while clock high is stop.
// - Repeated start begins a new transfer.
// - One data byte per transfer, acknowledged.
// - Acknowledge holds data low through clock high.
// - Wrong address leaves data released: not-acknowledge.
// - Further bytes get not-acknowledge; master stops.
// - Registers 0x00 to 0x0B are read-write; only 0x00 to 0x05 are stored here, 0x06 to 0x0B read zero.
// - Registers 0x0E and 0x0F are read-only.
// - Register 0x00 holds four single-bit controls.
// - Register 0x01 holds the slice level code.
// - Register 0x02 holds the preemphasis code.
// - Register 0x03 holds the output swing code.
// - Register 0x04 holds slot A override and code.
// - Register 0x05 holds slot B override and code.
// - Control bits active high, port enabled at reset.
// - Override picks slot code, else default bandwidth.
// - Slice code 128 is zero shift, signed around.
// - Preemphasis code maps to 0 to 8 dB.
`timescale 1ns/1ps
`include "tws_map.vh"

module tws_slave_top (
   input wire clk_sys,
   input wire sys_rst,
   input wire sclPin,
   input wire sdaPin,
   output wire sdaOut,
   output wire sdaOe,
   input wire speedPinHigh,
   input wire speedPinLow,
   input wire [3:0] selRateStatus,
   input wire [6:0] selLosStatus,
   output reg outputOff,
   output reg losHighRange,
   output reg offsetCancelOff,
   output reg serialPortOff,
   output reg [7:0] sliceLevelCode,
   output reg sliceShiftNeg,
   output reg [6:0] sliceShiftMag,
   output reg [3:0] preemphasisCode,
   output reg [3:0] preemphasisDb,
   output reg [1:0] outputSwingCode,
   output reg bandwidthAOverride,
   output reg [3:0] bandwidthACode,
   output reg bandwidthBOverride,
   output reg [3:0] bandwidthBCode,
   output reg [1:0] bwSlot,
   output reg bwUseCode,
   output reg [3:0] bwCode,
   output reg busBusy
);

   // ==================================================
   // Transfer states, one-hot
   localparam [9:0] ST_IDLE = 10'h001;
   localparam [9:0] ST_DEV = 10'h002;
   localparam [9:0] ST_DEV_ACK = 10'h004;
   localparam [9:0] ST_PTR = 10'h008;
   localparam [9:0] ST_PTR_ACK = 10'h010;
   localparam [9:0] ST_WR = 10'h020;
   localparam [9:0] ST_WR_ACK = 10'h040;
   localparam [9:0] ST_RD = 10'h080;
   localparam [9:0] ST_RD_ACK = 10'h100;
   localparam [9:0] ST_SKIP = 10'h200;

   // ==================================================
   // Helper functions
   // True once a whole byte has been clocked
   function byteFull;
      input [3:0] cnt;
      begin
         byteFull = (cnt == `TWS_BITS_PER_BYTE);
      end
   endfunction

   // Magnitude of the threshold shift away from the zero code
   function [6:0] sliceMagnitude;
      input [7:0] code;
      reg [7:0] diff;
      begin
         diff = 8'h00;
         if (code < `TWS_SLICE_ZERO) begin
            diff = `TWS_SLICE_ZERO - code;
         end else begin
            diff = code - `TWS_SLICE_ZERO;
         end
         sliceMagnitude = diff[6:0];
      end
   endfunction

   // Preemphasis in whole dB, codes past the top step clamp
   function [3:0] preemphSteps;
      input [3:0] code;
      begin
         if (code > `TWS_PREEMPH_MAX_DB) begin
            preemphSteps = `TWS_PREEMPH_MAX_DB;
         end else begin
            preemphSteps = code;
         end
      end
   endfunction

   // ==================================================
   // Pin synchronisers and bus condition detect
   wire [3:0] pinSync;
   wire sclSync;
   wire sdaSync;
   wire speedHighSync;
   wire speedLowSync;
   reg sclPrev_reg;
   reg sdaPrev_reg;

   tws_pin_sync #(
      .WIDTH(4)
   ) uPinSync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pinAsync({speedPinHigh, speedPinLow, sdaPin, sclPin}),
      .pinIdle(4'hf),
      .pinSync(pinSync)
   );

   assign sclSync = pinSync[0];
   assign sdaSync = pinSync[1];
   assign speedLowSync = pinSync[2];
   assign speedHighSync = pinSync[3];

   // Previous samples taken from the second stage only
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
      end else begin
         sclPrev_reg <= sclSync;
         sdaPrev_reg <= sdaSync;
      end
   end

   wire sclRise = sclSync & ~sclPrev_reg;
   wire sclFall = ~sclSync & sclPrev_reg;
   wire sclHeld = sclSync & sclPrev_reg;
   wire startCond = sclHeld & sdaPrev_reg & ~sdaSync;
   wire stopCond = sclHeld & ~sdaPrev_reg & sdaSync;

   // ==================================================
   // Register bank
   wire [7:0] rdData;
   wire [3:0] ctrlBits;
   wire [7:0] sliceCode;
   wire [3:0] preemphCode;
   wire [1:0] swingCode;
   wire [4:0] bwA;
   wire [4:0] bwB;
   reg wrEn_reg;
   reg [7:0] wrData_reg;
   reg [7:0] ptr_reg;

   tws_reg_bank uRegBank (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .wrEn(wrEn_reg),
      .regAddr(ptr_reg),
      .wrData(wrData_reg),
      .selRateStatus(selRateStatus),
      .selLosStatus(selLosStatus),
      .rdData(rdData),
      .ctrlBits(ctrlBits),
      .sliceCode(sliceCode),
      .preemphCode(preemphCode),
      .swingCode(swingCode),
      .bwA(bwA),
      .bwB(bwB)
   );

   // ==================================================
   // Serial transfer engine
   reg [9:0] state_reg;
   reg [3:0] bitCnt_reg;
   reg [7:0] shift_reg;
   reg rw_reg;
   reg sdaOe_reg;

   // The device only ever pulls low; the pull-up makes the high level
   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_reg;

   // Data changes only after a seen clock fall, which keeps it stable
   // over the whole high phase of the following pulse
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         rw_reg <= 1'b0;
         sdaOe_reg <= 1'b0;
         wrEn_reg <= 1'b0;
         wrData_reg <= 8'h00;
         ptr_reg <= 8'h00;
      end else begin
         wrEn_reg <= 1'b0;
         if (stopCond) begin
            state_reg <= ST_IDLE;
            sdaOe_reg <= 1'b0;
         end else if (startCond) begin
            state_reg <= ST_DEV;
            bitCnt_reg <= 4'h0;
            sdaOe_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  sdaOe_reg <= 1'b0;
               end
               ST_DEV, ST_PTR, ST_WR: begin
                  // Receive a byte, MSB first, on rising clock
                  if (sclRise) begin
                     shift_reg <= {shift_reg[6:0], sdaSync};
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end else if (sclFall && byteFull(bitCnt_reg)) begin
                     bitCnt_reg <= 4'h0;
                     if (state_reg == ST_DEV) begin
                        if (shift_reg[7:1] == `TWS_DEV_ADDR && !serialPortOff) begin
                           rw_reg <= shift_reg[0];
                           sdaOe_reg <= 1'b1;
                           state_reg <= ST_DEV_ACK;
                        end else begin
                           state_reg <= ST_SKIP;
                        end
                     end else if (state_reg == ST_PTR) begin
                        ptr_reg <= shift_reg;
                        sdaOe_reg <= 1'b1;
                        state_reg <= ST_PTR_ACK;
                     end else begin
                        wrData_reg <= shift_reg;
                        wrEn_reg <= 1'b1;
                        sdaOe_reg <= 1'b1;
                        state_reg <= ST_WR_ACK;
                     end
                  end
               end
               ST_DEV_ACK: begin
                  // After the acknowledge pulse, release for a write or drive the first data bit for a read
                  if (sclFall) begin
                     if (rw_reg == `TWS_DIR_READ) begin
                        shift_reg <= rdData;
                        sdaOe_reg <= ~rdData[7];
                        state_reg <= ST_RD;
                     end else begin
                        sdaOe_reg <= 1'b0;
                        state_reg <= ST_PTR;
                     end
                  end
               end
               ST_PTR_ACK: begin
                  if (sclFall) begin
                     sdaOe_reg <= 1'b0;
                     state_reg <= ST_WR;
                  end
               end
               ST_WR_ACK: begin
                  // Only one data byte fits; later bytes see no pull-down
                  if (sclFall) begin
                     sdaOe_reg <= 1'b0;
                     state_reg <= ST_SKIP;
                  end
               end
               ST_RD: begin
                  // Shift out on falling clock, master samples on rising
                  if (sclRise) begin
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end else if (sclFall) begin
                     if (byteFull(bitCnt_reg)) begin
                        bitCnt_reg <= 4'h0;
                        sdaOe_reg <= 1'b0;
                        state_reg <= ST_RD_ACK;
                     end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sdaOe_reg <= ~shift_reg[6];
                     end
                  end
               end
               ST_RD_ACK: begin
                  // Master answers the single byte, then must stop
                  if (sclFall) begin
                     state_reg <= ST_SKIP;
                  end
               end
               ST_SKIP: begin
                  sdaOe_reg <= 1'b0;
               end
               default: begin
                  state_reg <= ST_IDLE;
                  sdaOe_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==================================================
   // Control outputs, decoded and registered
   // Bandwidth slots C and D live outside this block, so those pin
   // settings report the default path here
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         outputOff <= 1'b0;
         losHighRange <= 1'b0;
         offsetCancelOff <= 1'b0;
         serialPortOff <= 1'b0;
         sliceLevelCode <= `TWS_RST_SLICE;
         sliceShiftNeg <= 1'b0;
         sliceShiftMag <= 7'h00;
         preemphasisCode <= `TWS_RST_PREEMPH;
         preemphasisDb <= 4'h0;
         outputSwingCode <= `TWS_RST_SWING;
         bandwidthAOverride <= 1'b0;
         bandwidthACode <= 4'h0;
         bandwidthBOverride <= 1'b0;
         bandwidthBCode <= 4'h0;
         bwSlot <= 2'h0;
         bwUseCode <= 1'b0;
         bwCode <= 4'h0;
         busBusy <= 1'b0;
      end else begin
         outputOff <= ctrlBits[`TWS_BIT_OUTPUT_OFF];
         losHighRange <= ctrlBits[`TWS_BIT_LOS_HIGH];
         offsetCancelOff <= ctrlBits[`TWS_BIT_OC_OFF];
         serialPortOff <= ctrlBits[`TWS_BIT_PORT_OFF];
         sliceLevelCode <= sliceCode;
         sliceShiftNeg <= (sliceCode > `TWS_SLICE_ZERO);
         sliceShiftMag <= sliceMagnitude(sliceCode);
         preemphasisCode <= preemphCode;
         preemphasisDb <= preemphSteps(preemphCode);
         outputSwingCode <= swingCode;
         bandwidthAOverride <= bwA[4];
         bandwidthACode <= bwA[3:0];
         bandwidthBOverride <= bwB[4];
         bandwidthBCode <= bwB[3:0];
         bwSlot <= {speedHighSync, speedLowSync};
         case ({speedHighSync, speedLowSync})
            `TWS_SLOT_A: begin
               bwUseCode <= bwA[4];
               bwCode <= bwA[3:0];
            end
            `TWS_SLOT_B: begin
               bwUseCode <= bwB[4];
               bwCode <= bwB[3:0];
            end
            default: begin
               bwUseCode <= 1'b0;
               bwCode <= 4'h0;
            end
         endcase
         busBusy <= (state_reg != ST_IDLE);
      end
   end

endmodule // tws_slave_top

//--- dv/tb.sv
// Self-checking bench for the two-wire slave and its register bank.
// Assumes the bus master model and the checker are compiled first.
`timescale 1ns/1ps

module tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic sclPin;
   logic mstSda;
   logic speedPinHigh = 1'b0;
   logic speedPinLow = 1'b0;
   logic [3:0] selRateStatus = 4'ha;
   logic [6:0] selLosStatus = 7'h5a;
   wire sdaPin, sdaOut, sdaOe, outputOff, losHighRange, offsetCancelOff, serialPortOff;
   wire sliceShiftNeg, bandwidthAOverride, bandwidthBOverride, bwUseCode, busBusy;
   wire [7:0] sliceLevelCode;
   wire [6:0] sliceShiftMag;
   wire [3:0] preemphasisCode, preemphasisDb, bandwidthACode, bandwidthBCode, bwCode;
   wire [1:0] outputSwingCode, bwSlot;
   int errTotal = 0;
   int nChecks = 0;
   logic [7:0] msk [6] = '{8'h0f, 8'hff, 8'h0f, 8'h03, 8'h8f, 8'h8f};
   logic [7:0] patA [6] = '{8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
   logic [7:0] patB [6] = '{8'hf0, 8'h01, 8'h05, 8'hf2, 8'h75, 8'h8a};

   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   // Open-drain wire with pull-up: low if either party pulls
   assign sdaPin = mstSda & (sdaOe ? sdaOut : 1'b1);

   tws_slave_top tws_slave_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclPin(sclPin),
      .sdaPin(sdaPin), .sdaOut(sdaOut), .sdaOe(sdaOe), .speedPinHigh(speedPinHigh),
      .speedPinLow(speedPinLow), .selRateStatus(selRateStatus), .selLosStatus(selLosStatus),
      .outputOff(outputOff), .losHighRange(losHighRange), .offsetCancelOff(offsetCancelOff),
      .serialPortOff(serialPortOff), .sliceLevelCode(sliceLevelCode),
      .sliceShiftNeg(sliceShiftNeg), .sliceShiftMag(sliceShiftMag),
      .preemphasisCode(preemphasisCode), .preemphasisDb(preemphasisDb),
      .outputSwingCode(outputSwingCode), .bandwidthAOverride(bandwidthAOverride),
      .bandwidthACode(bandwidthACode), .bandwidthBOverride(bandwidthBOverride),
      .bandwidthBCode(bandwidthBCode), .bwSlot(bwSlot), .bwUseCode(bwUseCode),
      .bwCode(bwCode), .busBusy(busBusy));
   tws_bus_master tws_bus_master_inst (.scl(sclPin), .sda(mstSda), .sdaLine(sdaPin));

   // ==========
   // Shared tasks
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      nChecks++;
      if (g !== e) begin
         errTotal++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One byte from the master; the slave's acknowledge bit is judged
   task automatic sendb(input logic [7:0] d, input logic e);
      logic [7:0] q;
      logic k;
      tws_bus_master_inst.xbyte(d, 1'b1, q, k);
      chk("ack", {7'h0, e}, {7'h0, k});
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tws_bus_master_inst.start();
      sendb(8'h88, 1'b0);
      sendb(a, 1'b0);
      sendb(d, 1'b0);
      tws_bus_master_inst.stop();
   endtask

   // Pointer write, repeated start, one byte back, master refuses more
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      logic k;
      tws_bus_master_inst.start();
      sendb(8'h88, 1'b0);
      sendb(a, 1'b0);
      tws_bus_master_inst.start();
      sendb(8'h89, 1'b0);
      tws_bus_master_inst.xbyte(8'hff, 1'b1, q, k);
      tws_bus_master_inst.stop();
   endtask

   // ==========
   // Scenarios
   task automatic t_reset();
      logic [7:0] q;
      chk("idle", 8'h00, {6'h0, busBusy, sdaOe});
      chk("ctrl", 8'h00, {4'h0, outputOff, losHighRange, offsetCancelOff, serialPortOff});
      for (int a = 0; a < 6; a++) begin
         rd(8'(a), q);
         chk("reg reset", (a == 1) ? 8'h80 : 8'h00, q);
      end
   endtask

   // Write all six, read back masked, then judge the setting pins
   task automatic t_rw(input logic [7:0] p [6]);
      logic [7:0] q;
      logic [7:0] s;
      for (int a = 0; a < 6; a++) begin
         wr(8'(a), p[a]);
      end
      for (int a = 0; a < 6; a++) begin
         rd(8'(a), q);
         chk("reg", p[a] & msk[a], q);
      end
      s = p[1];
      chk("ctrl", p[0] & msk[0], {4'h0, outputOff, losHighRange, offsetCancelOff,
         serialPortOff});
      chk("slice", s, sliceLevelCode);
      chk("shift", (s > 8'h80) ? {1'b1, 7'(s - 8'h80)} : {1'b0, 7'(8'h80 - s)},
         {sliceShiftNeg, sliceShiftMag});
      chk("preemph", p[2] & msk[2], {4'h0, preemphasisCode});
      chk("db", (p[2][3:0] > 4'h8) ? 8'h08 : {4'h0, p[2][3:0]}, {4'h0, preemphasisDb});
      chk("swing", p[3] & msk[3], {6'h0, outputSwingCode});
      chk("slot a", p[4] & msk[4], {bandwidthAOverride, 3'h0, bandwidthACode});
      chk("slot b", p[5] & msk[5], {bandwidthBOverride, 3'h0, bandwidthBCode});
   endtask

   // Rate pins walk all four slots; only A and B carry a code
   task automatic t_slots();
      logic [4:0] e;
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_sys) #1;
         {speedPinHigh, speedPinLow} = 2'(s);
         repeat (8) @(posedge clk_sys);
         #1;
         e = (s == 0) ? {patB[4][7], patB[4][3:0]} : (s == 1) ? {patB[5][7], patB[5][3:0]} : 5'h0;
         chk("slot", {1'b0, 2'(s), e}, {bwSlot, bwUseCode, bwCode});
      end
   endtask
   task automatic t_ro();
      logic [7:0] q;
      wr(8'h0e, 8'hff);
      wr(8'h0f, 8'h00);
      wr(8'h06, 8'hff);
      rd(8'h0e, q);
      chk("rate status", 8'h0a, q);
      rd(8'h0f, q);
      chk("los status", 8'h5a, q);
      rd(8'h06, q);
      chk("unused", 8'h00, q);
   endtask

   // Foreign addresses get no acknowledge and change nothing
   task automatic t_nack();
      logic [7:0] q;
      logic [7:0] bad [2] = '{8'h8a, 8'h09};
      for (int i = 0; i < 2; i++) begin
         tws_bus_master_inst.start();
         sendb(bad[i], 1'b1);
         sendb(8'h01, 1'b1);
         sendb(8'h66, 1'b1);
         tws_bus_master_inst.stop();
      end
      rd(8'h01, q);
      chk("untouched", patB[1], q);
   endtask

   task automatic t_extra();
      logic [7:0] q;
      tws_bus_master_inst.start();
      sendb(8'h88, 1'b0);
      sendb(8'h01, 1'b0);
      sendb(8'h3c, 1'b0);
      sendb(8'h5a, 1'b1);
      tws_bus_master_inst.stop();
      rd(8'h01, q);
      chk("one byte", 8'h3c, q);
   endtask

   task automatic t_slow();
      logic [7:0] q;
      tws_bus_master_inst.qtr = 90.0;
      wr(8'h02, 8'h07);
      rd(8'h02, q);
      chk("slow", 8'h07, q);
      tws_bus_master_inst.qtr = 31.25;
   endtask

   // Turning the port off must silence the address acknowledge
   task automatic t_off();
      wr(8'h00, 8'h01);
      chk("port off", 8'h01, {7'h0, serialPortOff});
      tws_bus_master_inst.start();
      sendb(8'h88, 1'b1);
      tws_bus_master_inst.stop();
   endtask

   task automatic end_of_test();
      if (errTotal == 0 && nChecks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog at over twice the expected run
   initial begin
      #600000;
      errTotal++;
      end_of_test();
   end

   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      t_reset();
      t_rw(patA);
      t_rw(patB);
      t_slots();
      t_ro();
      t_nack();
      t_extra();
      t_slow();
      t_off();
      end_of_test();
   end
endmodule // tb

//--- dv/tws_bus_master.sv
// Behavioural two-wire bus master facing the slave's pins.
// Assumes a pull-up on the data wire, resolved by the testbench.
`timescale 1ns/1ps

module tws_bus_master (
   output logic scl,
   output logic sda,
   input wire logic sdaLine
);
   // Quarter bit time; larger means a slower master
   realtime qtr = 31.25;

   // ==========
   // Idle and conditions
   // Both lines released high between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // Data falls while the clock is high; also serves as repeated start
   task automatic start();
      sda = 1'b1;
      #qtr;
      scl = 1'b1;
      #qtr;
      sda = 1'b0;
      #qtr;
      scl = 1'b0;
      #qtr;
   endtask

   // Data rises while the clock is high
   task automatic stop();
      sda = 1'b0;
      #qtr;
      scl = 1'b1;
      #qtr;
      sda = 1'b1;
      #qtr;
      #qtr;
   endtask

   // ==========
   // Bits and bytes
   // Data changes only in the low phase, sampled mid-high
   task automatic bitx(input logic b, output logic r);
      sda = b;
      #qtr;
      scl = 1'b1;
      #qtr;
      r = sdaLine;
      #qtr;
      scl = 1'b0;
      #qtr;
   endtask

   // Eight bits most significant first, then the acknowledge slot
   task automatic xbyte(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                        output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r);
         q[i] = r;
      end
      bitx(ackIn, ack);
   endtask
endmodule // tws_bus_master

//--- dv/tws_slave_top_sva.sv
// Checker for the two-wire slave: pin timing and derived outputs.
// Assumes it is bound to tws_slave_top and sees only its ports.
`timescale 1ns/1ps

module tws_slave_top_sva (
   input wire clk_sys,
   input wire sys_rst,
   input wire sclPin,
   input wire sdaPin,
   input wire sdaOe,
   input wire outputOff,
   input wire serialPortOff,
   input wire [7:0] sliceLevelCode,
   input wire sliceShiftNeg,
   input wire [6:0] sliceShiftMag,
   input wire [3:0] preemphasisCode,
   input wire [3:0] preemphasisDb,
   input wire bandwidthAOverride,
   input wire [3:0] bandwidthACode,
   input wire [1:0] bwSlot,
   input wire bwUseCode,
   input wire [3:0] bwCode,
   input wire busBusy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ==========
   // Bus pins
   // The pull-down may only move while the clock is low
   oe_scl_low_a: assert property (!$stable(sdaOe) |-> !sclPin)
      else $error("data drive moved with clock high");
   idle_free_a: assert property (!busBusy && !$past(busBusy) |-> !sdaOe)
      else $error("data driven on idle bus");
   start_busy_a: assert property ($fell(sdaPin) && sclPin && $past(sclPin)
      && !serialPortOff |-> ##[1:8] busBusy)
      else $error("start not seen");
   stop_idle_a: assert property ($rose(sdaPin) && sclPin && $past(sclPin)
      |-> ##[1:8] !busBusy)
      else $error("stop not seen");
   // Settings change only inside a transfer
   quiet_idle_a: assert property (!$stable({outputOff, serialPortOff, sliceLevelCode,
      preemphasisCode}) |-> busBusy)
      else $error("setting changed outside a transfer");

   // ==========
   // Derived outputs, checked once their source has settled
   slice_sign_a: assert property ($stable(sliceLevelCode) && sliceLevelCode != 8'h00
      |-> sliceShiftNeg == (sliceLevelCode > 8'h80) && sliceShiftMag == 7'((sliceLevelCode
      > 8'h80) ? sliceLevelCode - 8'h80 : 8'h80 - sliceLevelCode))
      else $error("slice shift wrong");
   preemph_db_a: assert property ($stable(preemphasisCode) |-> preemphasisDb ==
      ((preemphasisCode > 4'h8) ? 4'h8 : preemphasisCode))
      else $error("preemphasis level wrong");
   slot_a_sel_a: assert property ($stable({bwSlot, bandwidthAOverride, bandwidthACode})
      && bwSlot == 2'h0 |-> bwUseCode == bandwidthAOverride && bwCode == bandwidthACode)
      else $error("slot A selection wrong");
   slot_cd_off_a: assert property ($stable(bwSlot) && bwSlot[1] |-> !bwUseCode
      && bwCode == 4'h0)
      else $error("slot C or D reports a code");
endmodule // tws_slave_top_sva

bind tws_slave_top tws_slave_top_sva tws_slave_top_sva_inst (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .sclPin(sclPin), .sdaPin(sdaPin), .sdaOe(sdaOe), .outputOff(outputOff),
   .serialPortOff(serialPortOff), .sliceLevelCode(sliceLevelCode),
   .sliceShiftNeg(sliceShiftNeg), .sliceShiftMag(sliceShiftMag),
   .preemphasisCode(preemphasisCode), .preemphasisDb(preemphasisDb),
   .bandwidthAOverride(bandwidthAOverride), .bandwidthACode(bandwidthACode),
   .bwSlot(bwSlot), .bwUseCode(bwUseCode), .bwCode(bwCode), .busBusy(busBusy));

//--- shared/tws_map.vh
// Constants of the two-wire slave and its control register bank.
// Included by the core files by bare name; holds definitions only.
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// ==================================================
// Bus addressing
`define TWS_DEV_ADDR 7'h44
`define TWS_DIR_READ 1'b1
`define TWS_BITS_PER_BYTE 4'h8

// ==================================================
// Register offsets
`define TWS_REG_CTRL 8'h00
`define TWS_REG_SLICE 8'h01
`define TWS_REG_PREEMPH 8'h02
`define TWS_REG_SWING 8'h03
`define TWS_REG_BW_A 8'h04
`define TWS_REG_BW_B 8'h05
`define TWS_REG_LAST_RW 8'h0b
`define TWS_REG_SEL_RATE 8'h0e
`define TWS_REG_SEL_LOS 8'h0f

// ==================================================
// Field positions
`define TWS_BIT_OUTPUT_OFF 3
`define TWS_BIT_LOS_HIGH 2
`define TWS_BIT_OC_OFF 1
`define TWS_BIT_PORT_OFF 0
`define TWS_BIT_BW_OVERRIDE 7
`define TWS_BW_CODE_MSB 3
`define TWS_PREEMPH_MSB 3
`define TWS_SWING_MSB 1

// ==================================================
// Reset values and decode constants
`define TWS_RST_CTRL 4'h0
`define TWS_RST_SLICE 8'h80
`define TWS_RST_PREEMPH 4'h0
`define TWS_RST_SWING 2'h0
`define TWS_RST_BW 5'h00
`define TWS_SLICE_ZERO 8'h80
`define TWS_PREEMPH_MAX_DB 4'h8
`define TWS_SLOT_A 2'h0
`define TWS_SLOT_B 2'h1

`endif
